// ---- rtl/bss_sequencer.sv ----
/*
 * ballast start-up and filament supervision sequencer.
 * assumes asynchronous comparator levels and a preheat-time code from an outside decoder.
 */
// Overview of operation
// - hysteresis window only checks filaments, drives off
// - normal source current tests low-side filament
// - upper filament threshold crossed flags open low-side
// - no lamp-sense sink current raises source current
// - fault persists: monitor, withhold power-up
// - after start threshold wait before bus check
// - bus in corridor powers up, else back to filament check
// - power-up starts inverter at start frequency
// - PFC drive enabled fixed delay after inverter
// - bus must reach high level within window
// - soft start: fifteen equal timed frequency steps
// - preheat lasts the selected time, up to maximum
// - ignition: 127 equal timed frequency steps
// - ignition slope freezes sweep, keeps monitoring
// - ignition slope but no ignition in time: latched fault
// - pre-run fixed time then run mode
// - run mode enables full supervision
// - open low-side at start: block, clamp pin
// - reduced threshold and current until drop, restart
// - run-mode threshold: stop drives after delay
// - run-mode filament fault restarts full sequence
// - high-side returns: reduce current, check low-side
`timescale 1ns/1ps

module bss_sequencer
	import bss_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rstn,
	input  wire bss_sense_s          sense,
	input  wire logic [PH_SEL_W-1:0] preheat_time_set,
	output bss_drive_s               drive
);

	typedef enum logic [3:0] {
		ST_LOCKOUT,
		ST_CHECK,
		ST_FIL_FAULT,
		ST_BUS_SETTLE,
		ST_BUS_CHECK,
		ST_SOFT,
		ST_PREHEAT,
		ST_IGNITE,
		ST_PRERUN,
		ST_RUN,
		ST_RUN_FAULT,
		ST_LATCHED
	} bss_state_e;

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers

	localparam int unsigned SENSE_W = $bits(bss_sense_s);

	logic [SENSE_W-1:0] sync1_q;
	logic [SENSE_W-1:0] sync2_q;
	logic [PH_SEL_W-1:0] ph_sync1_q;
	logic [PH_SEL_W-1:0] ph_sync2_q;
	bss_sense_s s;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			ph_sync1_q <= '0;
			ph_sync2_q <= '0;
		end else begin
			sync1_q <= sense;
			sync2_q <= sync1_q;
			ph_sync1_q <= preheat_time_set;
			ph_sync2_q <= ph_sync1_q;
		end
	end

	assign s = bss_sense_s'(sync2_q);

	// high-side filament present on every enabled lamp-sense input
	function automatic logic hs_ok(input bss_sense_s x);
		hs_ok = (!x.lvs_a_enabled || x.lvs_a_current) && (!x.lvs_b_enabled || x.lvs_b_current);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	bss_state_e      state_q;
	logic [CNT_W-1:0] tmr_q;
	logic [CNT_W-1:0] pfc_tmr_q;
	logic [STEP_W-1:0] step_q;
	logic            hs_fault_q;
	logic            pfc_on_q;
	logic            frozen_q;
	logic [CNT_W-1:0] preheat_cyc;
	logic            supply_low;

	// preheat duration scaled linearly from zero to the maximum
	assign preheat_cyc = CNT_W'((64'(ph_sync2_q) * 64'(PREHEAT_MAX_CYC)) / 64'(PH_SEL_MAX));
	assign supply_low = !s.supply_above_low;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_LOCKOUT;
			tmr_q <= '0;
			step_q <= '0;
			hs_fault_q <= 1'b0;
			frozen_q <= 1'b0;
		end else if (supply_low && state_q != ST_LATCHED) begin
			state_q <= ST_LOCKOUT;
			tmr_q <= '0;
			step_q <= '0;
			hs_fault_q <= 1'b0;
			frozen_q <= 1'b0;
		end else begin
			tmr_q <= tmr_q + CNT_W'(1);
			case (state_q)
				ST_LOCKOUT: begin
					tmr_q <= '0;
					state_q <= ST_CHECK;
				end
				ST_CHECK: begin
					tmr_q <= '0;
					hs_fault_q <= !hs_ok(s);
					if (s.fil_above_upper) begin
						state_q <= ST_FIL_FAULT;
					end else if (s.supply_above_start && hs_ok(s)) begin
						state_q <= ST_BUS_SETTLE;
					end
				end
				ST_FIL_FAULT: begin
					tmr_q <= '0;
					hs_fault_q <= !hs_ok(s);
					if (hs_ok(s) && !s.fil_above_lower) begin
						state_q <= ST_CHECK;
					end
				end
				ST_BUS_SETTLE: begin
					if (tmr_q >= CNT_W'(BUS_SETTLE_CYC - 1)) begin
						tmr_q <= '0;
						if (!s.bus_open_loop && !s.bus_over_start) begin
							state_q <= ST_BUS_CHECK;
						end else begin
							state_q <= ST_CHECK;
						end
					end
				end
				ST_BUS_CHECK: begin
					if (s.bus_above_high) begin
						tmr_q <= '0;
						step_q <= '0;
						state_q <= ST_SOFT;
					end else if (tmr_q >= CNT_W'(BUS_CHECK_CYC - 1)) begin
						tmr_q <= '0;
						state_q <= ST_CHECK;
					end
				end
				ST_SOFT: begin
					if (tmr_q >= CNT_W'(SOFT_STEP_CYC - 1)) begin
						tmr_q <= '0;
						if (step_q == STEP_W'(SOFT_STEPS - 1)) begin
							step_q <= STEP_W'(SOFT_STEPS);
							state_q <= ST_PREHEAT;
						end else begin
							step_q <= step_q + STEP_W'(1);
						end
					end
				end
				ST_PREHEAT: begin
					if (tmr_q >= preheat_cyc) begin
						tmr_q <= '0;
						step_q <= '0;
						frozen_q <= 1'b0;
						state_q <= ST_IGNITE;
					end
				end
				ST_IGNITE: begin
					// tmr_q times the whole phase, step timer derived by modulo
					if (s.lsc_ignition) begin
						frozen_q <= 1'b1;
					end
					if (s.lsc_ignited || (!frozen_q && step_q == STEP_W'(IGN_STEPS))) begin
						tmr_q <= '0;
						state_q <= ST_PRERUN;
					end else if (tmr_q >= CNT_W'(IGN_MAX_CYC - 1)) begin
						state_q <= ST_LATCHED;
					end else if (!frozen_q && !s.lsc_ignition && step_q != STEP_W'(IGN_STEPS)
						&& (tmr_q % CNT_W'(IGN_STEP_CYC)) == CNT_W'(IGN_STEP_CYC - 1)) begin
						step_q <= step_q + STEP_W'(1);
					end
				end
				ST_PRERUN: begin
					if (tmr_q >= CNT_W'(PRERUN_CYC - 1)) begin
						tmr_q <= '0;
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!s.fil_above_run) begin
						tmr_q <= '0;
					end else if (tmr_q >= CNT_W'(RUN_FIL_CYC - 1)) begin
						tmr_q <= '0;
						state_q <= ST_RUN_FAULT;
					end
				end
				ST_RUN_FAULT: begin
					tmr_q <= '0;
					if (!s.fil_above_lower) begin
						state_q <= ST_CHECK;
					end
				end
				ST_LATCHED: begin
					tmr_q <= '0;
				end
				default: begin
					state_q <= ST_LOCKOUT;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pfc start delay

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pfc_tmr_q <= '0;
			pfc_on_q <= 1'b0;
		end else if (state_q inside {ST_LOCKOUT, ST_CHECK, ST_FIL_FAULT, ST_BUS_SETTLE,
			ST_RUN_FAULT, ST_LATCHED}) begin
			pfc_tmr_q <= '0;
			pfc_on_q <= 1'b0;
		end else if (!pfc_on_q) begin
			pfc_tmr_q <= pfc_tmr_q + CNT_W'(1);
			if (pfc_tmr_q >= CNT_W'(PFC_DELAY_CYC - 2)) begin
				pfc_on_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registered outputs

	logic gates_on;
	assign gates_on = state_q inside {ST_BUS_CHECK, ST_SOFT, ST_PREHEAT, ST_IGNITE,
		ST_PRERUN, ST_RUN};

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			drive <= '0;
		end else begin
			drive.inverter_enable <= gates_on;
			drive.pfc_enable <= gates_on && pfc_on_q;
			drive.supervision_enable <= (state_q == ST_RUN);
			drive.ignition_control <= (state_q == ST_IGNITE) && frozen_q;
			drive.fil_clamp <= (state_q == ST_FIL_FAULT) && !hs_fault_q;
			drive.fil_thresh_low <= state_q inside {ST_FIL_FAULT, ST_RUN_FAULT};
			if (state_q == ST_LOCKOUT || state_q == ST_LATCHED) begin
				drive.src_sel <= BSS_SRC_OFF;
			end else if (hs_fault_q) begin
				drive.src_sel <= BSS_SRC_RAISED;
			end else if (state_q inside {ST_FIL_FAULT, ST_RUN_FAULT}) begin
				drive.src_sel <= BSS_SRC_REDUCED;
			end else begin
				drive.src_sel <= BSS_SRC_NORMAL;
			end
			case (state_q)
				ST_SOFT: drive.freq_mode <= BSS_FREQ_SOFT;
				ST_PREHEAT: drive.freq_mode <= BSS_FREQ_HOLD;
				ST_IGNITE, ST_PRERUN, ST_RUN: drive.freq_mode <= BSS_FREQ_IGN;
				default: drive.freq_mode <= BSS_FREQ_START;
			endcase
			drive.freq_step <= step_q;
		end
	end

endmodule // bss_sequencer

// ---- shared/bss_pkg.sv ----
/*
 * package for the ballast start-up sequencer: frequency and source modes, timing counts, carriers.
 * assumes a 50 MHz reference clock; analogue comparators and level translation are outside.
 */
package bss_pkg;

	localparam int unsigned CLK_HZ = 50_000_000;

	localparam int unsigned BUS_SETTLE_US = 130;
	localparam int unsigned PFC_DELAY_US = 300;
	localparam int unsigned BUS_CHECK_MS = 80;
	localparam int unsigned SOFT_STEP_US = 650;
	localparam int unsigned PREHEAT_MAX_MS = 2500;
	localparam int unsigned IGN_STEP_US = 324;
	localparam int unsigned IGN_MAX_MS = 237;
	localparam int unsigned PRERUN_MS = 625;
	localparam int unsigned RUN_FIL_US = 620;

	localparam int unsigned BUS_SETTLE_CYC = BUS_SETTLE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned PFC_DELAY_CYC = PFC_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BUS_CHECK_CYC = BUS_CHECK_MS * (CLK_HZ / 1_000);
	localparam int unsigned SOFT_STEP_CYC = SOFT_STEP_US * (CLK_HZ / 1_000_000);
	localparam int unsigned PREHEAT_MAX_CYC = PREHEAT_MAX_MS * (CLK_HZ / 1_000);
	localparam int unsigned IGN_STEP_CYC = IGN_STEP_US * (CLK_HZ / 1_000_000);
	localparam int unsigned IGN_MAX_CYC = IGN_MAX_MS * (CLK_HZ / 1_000);
	localparam int unsigned PRERUN_CYC = PRERUN_MS * (CLK_HZ / 1_000);
	localparam int unsigned RUN_FIL_CYC = RUN_FIL_US * (CLK_HZ / 1_000_000);

	localparam int unsigned SOFT_STEPS = 15;
	localparam int unsigned IGN_STEPS = 127;

	localparam int unsigned CNT_W = 27;
	localparam int unsigned PH_SEL_W = 8;
	localparam int unsigned STEP_W = 7;
	localparam int unsigned PH_SEL_MAX = 255;

	typedef enum logic [1:0] {
		BSS_FREQ_START,
		BSS_FREQ_SOFT,
		BSS_FREQ_HOLD,
		BSS_FREQ_IGN
	} bss_freq_e;

	typedef enum logic [1:0] {
		BSS_SRC_OFF,
		BSS_SRC_NORMAL,
		BSS_SRC_REDUCED,
		BSS_SRC_RAISED
	} bss_src_e;

	// comparator outputs from the sense pins
	typedef struct packed {
		logic supply_above_low;
		logic supply_above_start;
		logic bus_open_loop;
		logic bus_over_start;
		logic bus_above_high;
		logic fil_above_upper;
		logic fil_above_lower;
		logic fil_above_run;
		logic lvs_a_current;
		logic lvs_b_current;
		logic lvs_a_enabled;
		logic lvs_b_enabled;
		logic lsc_ignition;
		logic lsc_ignited;
	} bss_sense_s;

	// drive and analogue control outputs
	typedef struct packed {
		logic       inverter_enable;
		logic       pfc_enable;
		logic       supervision_enable;
		logic       ignition_control;
		logic       fil_clamp;
		logic       fil_thresh_low;
		bss_src_e   src_sel;
		bss_freq_e  freq_mode;
		logic [6:0] freq_step;
	} bss_drive_s;

endpackage : bss_pkg

// ---- verification/bss_sense_model.sv ----
/*
 * comparator model of the sense pins behind the sequencer.
 * assumes bus in corridor; filament states come from the bench.
 */
`timescale 1ns/1ps
module bss_sense_model
	import bss_pkg::*;
(
	input  wire logic       sup_low,
	input  wire logic       sup_start,
	input  wire logic       ls_open,
	input  wire logic       hs_open,
	input  wire logic       bus_high,
	input  wire bss_drive_s drive,
	output bss_sense_s      sense
);
	logic v_hi;
	// pin high while filament open or source raised
	assign v_hi = ls_open || (drive.src_sel == BSS_SRC_RAISED);
	always_comb begin
		sense = '0;
		sense.supply_above_low = sup_low;
		sense.supply_above_start = sup_start;
		sense.bus_above_high = bus_high;
		sense.fil_above_upper = v_hi;
		sense.fil_above_lower = v_hi;
		sense.fil_above_run = ls_open;
		sense.lvs_a_enabled = 1'b1;
		sense.lvs_b_enabled = 1'b1;
		sense.lvs_a_current = !hs_open;
		sense.lvs_b_current = !hs_open;
	end
endmodule // bss_sense_model

// ---- verification/bss_sequencer_monitor.sv ----
/*
 * checker for the sequencer ports.
 * assumes bind onto bss_sequencer.
 */
`timescale 1ns/1ps
module bss_sequencer_monitor
	import bss_pkg::*;
(
	input wire logic                ref_clk,
	input wire logic                rstn,
	input wire bss_sense_s          sense,
	input wire logic [PH_SEL_W-1:0] preheat_time_set,
	input wire bss_drive_s          drive
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	int unsigned inv_cnt_q;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			inv_cnt_q <= 0;
		else if (!drive.inverter_enable)
			inv_cnt_q <= 0;
		else if (inv_cnt_q < PFC_DELAY_CYC)
			inv_cnt_q <= inv_cnt_q + 1;
	end
	AST_RESET_IDLE: assert property ($rose(rstn) |-> drive == '0)
		else $error("drive not idle after reset");
	AST_CLAMP_OFF: assert property (drive.fil_clamp |-> !drive.inverter_enable && !drive.pfc_enable)
		else $error("drive active while clamped");
	AST_CLAMP_SRC: assert property (drive.fil_clamp |-> drive.src_sel == BSS_SRC_REDUCED)
		else $error("clamp without reduced source");
	AST_RAISED_OFF: assert property (drive.src_sel == BSS_SRC_RAISED |-> !drive.inverter_enable)
		else $error("inverter on with raised source");
	AST_PFC_DELAY: assert property ($rose(drive.pfc_enable) |-> inv_cnt_q >= PFC_DELAY_CYC - 10)
		else $error("pfc started early");
	AST_INV_START: assert property ($rose(drive.inverter_enable) |-> drive.freq_mode == BSS_FREQ_START)
		else $error("inverter not at start frequency");
	AST_SOFT_STEP: assert property (drive.freq_mode == BSS_FREQ_SOFT && $past(drive.freq_mode) == BSS_FREQ_SOFT && $changed(drive.freq_step) |-> drive.freq_step == $past(drive.freq_step) + 7'h01)
		else $error("soft step not by one");
	AST_SOFT_MAX: assert property (drive.freq_mode == BSS_FREQ_SOFT |-> drive.freq_step <= 7'h0F)
		else $error("soft step beyond fifteen");
	AST_IGN_FROZEN: assert property (drive.ignition_control && $past(drive.ignition_control) |-> $stable(drive.freq_step))
		else $error("sweep moved while frozen");
	AST_LOCKOUT: assert property (!sense.supply_above_low [*5] |-> !drive.inverter_enable && !drive.pfc_enable)
		else $error("drive on in lock-out");
endmodule // bss_sequencer_monitor
bind bss_sequencer bss_sequencer_monitor u_bss_sequencer_monitor (.ref_clk(ref_clk), .rstn(rstn),
	.sense(sense), .preheat_time_set(preheat_time_set), .drive(drive));

// ---- verification/bss_sequencer_tb_top.sv ----
/*
 * self-checking bench for the sequencer.
 * assumes the sense model stands in for the analogue pins.
 */
`timescale 1ns/1ps
module bss_sequencer_tb_top
	import bss_pkg::*;
;
	logic                ref_clk, rstn, sup_low, sup_start, ls_open, hs_open, bus_high;
	logic [PH_SEL_W-1:0] ph_set;
	logic [15:0]         lfsr_q;
	bss_sense_s          sense;
	bss_drive_s          drive;
	int                  error_cnt, compares, n;
	bss_sequencer u_bss_sequencer (.ref_clk(ref_clk), .rstn(rstn), .sense(sense),
		.preheat_time_set(ph_set), .drive(drive));
	bss_sense_model u_bss_sense_model (.sup_low(sup_low), .sup_start(sup_start),
		.ls_open(ls_open), .hs_open(hs_open), .bus_high(bus_high), .drive(drive), .sense(sense));
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("Error t=%0t got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask
	task automatic setin(input logic [4:0] v);
		@(posedge ref_clk);
		{sup_low, sup_start, ls_open, hs_open, bus_high} <= v;
	endtask
	task automatic settle();
		repeat (16) @(posedge ref_clk);
		#1;
	endtask
	// sel 0 inverter, 1 pfc, 2 soft mode, 3 step change
	task automatic wait_for(input int sel, input int lim, output int cyc);
		logic       hit;
		logic [6:0] s0;
		s0 = drive.freq_step;
		cyc = 0;
		hit = 0;
		while (!hit) begin
			@(posedge ref_clk);
			#1;
			cyc++;
			case (sel)
				0: hit = drive.inverter_enable === 1'b1;
				1: hit = drive.pfc_enable === 1'b1;
				2: hit = drive.freq_mode === BSS_FREQ_SOFT;
				default: hit = drive.freq_step !== s0;
			endcase
			if (!hit && cyc >= lim) begin
				chk(sel, 32'hFF);
				tally_and_finish();
			end
		end
	endtask
	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		rstn = 0;
		{sup_low, sup_start, ls_open, hs_open, bus_high} = 5'h00;
		ph_set = 8'h00;
		lfsr_q = 16'h4C80;
		error_cnt = 0;
		compares = 0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1;
		@(posedge ref_clk);
		#1;
		chk(drive, 32'h0);
		lfsr_q = lfsr_next(lfsr_q);
		setin(5'h14);
		ph_set <= lfsr_q[7:0];
		settle();
		chk(drive.fil_clamp, 1);
		chk(drive.src_sel, BSS_SRC_REDUCED);
		chk(drive.inverter_enable, 0);
		chk(drive.fil_thresh_low, 1);
		setin(5'h10);
		settle();
		chk(drive.src_sel, BSS_SRC_NORMAL);
		chk(drive.fil_clamp, 0);
		chk(drive.fil_thresh_low, 0);
		$display("low-side filament test done");
		setin(5'h12);
		settle();
		chk(drive.src_sel, BSS_SRC_RAISED);
		chk(drive.pfc_enable, 0);
		setin(5'h10);
		settle();
		chk(drive.src_sel, BSS_SRC_NORMAL);
		chk(drive.inverter_enable, 0);
		$display("high-side filament test done");
		setin(5'h18);
		wait_for(0, 7000, n);
		chk(n >= BUS_SETTLE_CYC && n <= BUS_SETTLE_CYC + 12, 1);
		chk(drive.freq_mode, BSS_FREQ_START);
		chk(drive.pfc_enable, 0);
		chk(drive.supervision_enable, 0);
		chk(drive.ignition_control, 0);
		wait_for(1, 16000, n);
		chk(n >= PFC_DELAY_CYC - 10 && n <= PFC_DELAY_CYC + 10, 1);
		lfsr_q = lfsr_next(lfsr_q);
		repeat (lfsr_q[7:0]) @(posedge ref_clk);
		setin(5'h19);
		wait_for(2, 20, n);
		wait_for(3, 33000, n);
		chk(drive.freq_step, 1);
		wait_for(3, 33000, n);
		chk(n, SOFT_STEP_CYC);
		$display("power-up test done");
		setin(5'h00);
		settle();
		chk(drive.inverter_enable, 0);
		chk(drive.pfc_enable, 0);
		chk(drive.supervision_enable, 0);
		$display("lock-out test done");
		tally_and_finish();
	end
endmodule // bss_sequencer_tb_top
